// ---- bench/cir_regs_props.sv ----
// concurrent checks on the configuration register bank ports
`timescale 1ns/1ps
`default_nettype none
module cir_regs_props (
  // clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // register access port
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic [11:0] acc_addr,
  input wire logic [31:0] acc_wdata,
  input wire logic        acc_priv,
  input wire logic        acc_secure,
  input wire logic        acc_debug,
  input wire logic [31:0] acc_rdata_r,
  input wire logic        acc_ack_r,
  input wire logic        bus_fault_exception_r,
  // context and memory control
  input wire logic        unpriv_debug_access_enable_s,
  input wire logic        unpriv_debug_access_enable_ns,
  input wire logic        tcm_lock_input,
  input wire logic        instr_mem_enable_init_input,
  input wire logic        sub_itcm_req,
  input wire logic        sw_dtcm_req,
  input wire logic        itcm_route_tcm_r,
  input wire logic        dtcm_route_axi_r,
  input wire logic        itcm_enable_r,
  input wire logic        dtcm_enable_r
);
  import cir_pkg::*;
  // ----------------------------------------------------------
  // helpers
  // ----------------------------------------------------------
  logic        mapped;
  logic        wbit;
  logic [31:0] pfr0;
  // unmapped offsets answer zero without a fault, so keep them apart
  assign mapped = acc_addr inside {CIR_OFF_SEL, CIR_OFF_RD, CIR_OFF_PFR0,
                                   CIR_OFF_ITCM, CIR_OFF_DTCM};
  assign wbit   = acc_wdata[CIR_EN_BIT];
  assign pfr0   = {CIR_RAS_V1, 20'h0_0000, CIR_ISA_CMP, CIR_ISA_WIDE};
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // ----------------------------------------------------------
  // assertions
  // ----------------------------------------------------------
  ack_timing_a: assert property (acc_valid |=> acc_ack_r)
    else $error("access not answered after one cycle");
  ack_quiet_a: assert property (
    !acc_valid |=> !acc_ack_r && !bus_fault_exception_r)
    else $error("answer without a request");
  unpriv_fault_a: assert property (
    acc_valid && !acc_priv && !acc_debug && mapped
    |=> bus_fault_exception_r && acc_rdata_r == 32'h0)
    else $error("unprivileged access not refused");
  feature_id_a: assert property (
    acc_valid && !acc_write && acc_priv && acc_addr == CIR_OFF_PFR0
    |=> acc_rdata_r == pfr0 && !bus_fault_exception_r)
    else $error("feature id value wrong");
  debug_id_a: assert property (
    acc_valid && !acc_write && acc_debug && acc_addr == CIR_OFF_PFR0 &&
    (unpriv_debug_access_enable_s || unpriv_debug_access_enable_ns)
    |=> !bus_fault_exception_r && acc_rdata_r == pfr0)
    else $error("debug read of feature id refused");
  lock_hold_a: assert property (
    acc_valid && acc_write && tcm_lock_input && acc_addr == CIR_OFF_ITCM
    |=> ##1 $stable(itcm_enable_r))
    else $error("locked memory control changed");
  enable_init_a: assert property (
    $fell(srst) |=> itcm_enable_r == $past(instr_mem_enable_init_input))
    else $error("enable not loaded from init input");
  enable_write_a: assert property (
    acc_valid && acc_write && acc_priv && acc_secure && !tcm_lock_input &&
    acc_addr == CIR_OFF_ITCM |=> ##1 itcm_enable_r == $past(wbit, 2))
    else $error("enable bit not written");
  sub_route_a: assert property (sub_itcm_req |=> itcm_route_tcm_r)
    else $error("subordinate access not sent to memory");
  sw_axi_a: assert property (
    sw_dtcm_req && !dtcm_enable_r |=> dtcm_route_axi_r)
    else $error("disabled memory access not sent to main bus");
endmodule
bind cir_regs cir_regs_props u_cir_regs_props (
  .clock, .srst, .acc_valid, .acc_write, .acc_addr, .acc_wdata, .acc_priv,
  .acc_secure, .acc_debug, .acc_rdata_r, .acc_ack_r, .bus_fault_exception_r,
  .unpriv_debug_access_enable_s, .unpriv_debug_access_enable_ns,
  .tcm_lock_input, .instr_mem_enable_init_input, .sub_itcm_req, .sw_dtcm_req,
  .itcm_route_tcm_r, .dtcm_route_axi_r, .itcm_enable_r, .dtcm_enable_r
);
`default_nettype wire

// ---- bench/cir_regs_tb.sv ----
// self-checking testbench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module cir_regs_tb;
  import cir_pkg::*;
  // ----------------------------------------------------------
  // signals and design
  // ----------------------------------------------------------
  logic clock = 1'b0, srst = 1'b1, acc_valid = 1'b0, acc_write = 1'b0;
  logic acc_priv = 1'b0, acc_secure = 1'b0, acc_debug = 1'b0;
  logic [11:0] acc_addr = 12'h000;
  logic [31:0] acc_wdata = 32'h0, acc_rdata_r, rd;
  logic acc_ack_r, bus_fault_exception_r, ak, ft;
  logic security_ext_present = 1'b1, fault_target_config = 1'b0;
  logic unpriv_debug_access_enable_s = 1'b0;
  logic unpriv_debug_access_enable_ns = 1'b0;
  logic [CIR_NPARAM*32-1:0] build_param_vec;
  logic [CIR_NSYS*32-1:0]   sys_param_vec;
  logic [CIR_VEC_W-1:0] interrupt_tier_vector, interrupt_disable_vector;
  logic l1_reset_disable_input = 1'b1, tcm_lock_input = 1'b0;
  logic [4:0] memory_alias_input = 5'h10;
  logic float_unit_cfg_input = 1'b1, vector_ext_cfg_input = 1'b1;
  logic nonsecure_protection_off_input = 1'b0;
  logic secure_protection_off_input = 1'b0, attribution_unit_off_input = 1'b0;
  logic [3:0] instr_mem_size_input = 4'h5, data_mem_size_input = 4'hF;
  logic instr_mem_enable_init_input = 1'b1;
  logic data_mem_enable_init_input = 1'b0;
  logic sw_itcm_req = 1'b0, sw_dtcm_req = 1'b0;
  logic sub_itcm_req = 1'b0, sub_dtcm_req = 1'b0;
  logic itcm_route_tcm_r, dtcm_route_tcm_r, itcm_route_axi_r;
  logic dtcm_route_axi_r, itcm_enable_r, dtcm_enable_r;
  int   err_count = 0, comparisons = 0;
  logic [31:0] u_codes[5] = '{32'h4, 32'h5, 32'h8, 32'h9, 32'hA};
  logic [11:0] m_offs[5] = '{12'h700, 12'h704, 12'hD40, 12'hF00, 12'hF04};
  cir_regs u_cir_regs (
    .clock, .srst, .acc_valid, .acc_write, .acc_addr, .acc_wdata, .acc_priv,
    .acc_secure, .acc_debug, .acc_rdata_r, .acc_ack_r, .bus_fault_exception_r,
    .security_ext_present, .fault_target_config,
    .unpriv_debug_access_enable_s, .unpriv_debug_access_enable_ns,
    .build_param_vec, .sys_param_vec, .interrupt_tier_vector,
    .interrupt_disable_vector, .l1_reset_disable_input, .memory_alias_input,
    .float_unit_cfg_input, .vector_ext_cfg_input,
    .nonsecure_protection_off_input, .secure_protection_off_input,
    .attribution_unit_off_input, .tcm_lock_input, .instr_mem_size_input,
    .data_mem_size_input, .instr_mem_enable_init_input,
    .data_mem_enable_init_input, .sw_itcm_req, .sw_dtcm_req, .sub_itcm_req,
    .sub_dtcm_req, .itcm_route_tcm_r, .dtcm_route_tcm_r, .itcm_route_axi_r,
    .dtcm_route_axi_r, .itcm_enable_r, .dtcm_enable_r);
  // free-running core clock, 8 ns period
  always #4 clock = ~clock;
  // ----------------------------------------------------------
  // access helpers
  // ----------------------------------------------------------
  // one access; one idle edge after it lets the lagging enable copies settle
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic p, s, g);
    @(negedge clock);
    {acc_valid, acc_write, acc_addr, acc_wdata} = {1'b1, w, a, d};
    {acc_priv, acc_secure, acc_debug} = {p, s, g};
    @(negedge clock);
    // the answer stands one cycle only, so take it before the next edge
    {rd, ak, ft} = {acc_rdata_r, acc_ack_r, bus_fault_exception_r};
    acc_valid = 1'b0;
    `CHK(ak, 1'b1)
    @(negedge clock);
  endtask
  task automatic cfg(input logic [31:0] code, input logic s);
    acc(1'b1, CIR_OFF_SEL, code, 1'b1, s, 1'b0);
    acc(1'b0, CIR_OFF_RD, 32'h0, 1'b1, s, 1'b0);
  endtask
  // expected readback, with every feature tie-off left enabling
  function automatic logic [31:0] exp_cfg(input int c);
    if (c >= 8'h01 && c <= 8'h12) return build_param_vec[(c-1)*32 +: 32];
    if (c >= 8'h20 && c < 8'h30) return interrupt_tier_vector[(c-32)*32 +: 32];
    if (c >= 8'h30 && c < 8'h40) return interrupt_disable_vector[(c-48)*32+:32];
    if (c inside {8'h41, 8'h45, 8'h46} || c > 8'h4C) return 32'h0;
    if (c == 8'h4B) return {31'h0, l1_reset_disable_input};
    if (c == 8'h4C) return {27'h0, memory_alias_input};
    if (c >= 8'h40) return sys_param_vec[(c-64)*32 +: 32];
    return 32'h0;
  endfunction
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------
  task automatic t_select;
    for (int c = 0; c <= 8'h52; c++) begin
      cfg(32'(c), 1'b1);
      `CHK(rd, exp_cfg(c))
    end
    acc(1'b1, CIR_OFF_SEL, CIR_SEL_ALIAS, 1'b1, 1'b1, 1'b0);
    memory_alias_input = 5'h03; // live tie-off, selector untouched
    acc(1'b0, CIR_OFF_RD, 32'h0, 1'b1, 1'b1, 1'b0);
    `CHK(rd, 32'h0000_0003)
    {float_unit_cfg_input, vector_ext_cfg_input} = 2'b00;
    {nonsecure_protection_off_input, secure_protection_off_input} = 2'b11;
    attribution_unit_off_input = 1'b1;
    foreach (u_codes[i]) begin
      cfg(u_codes[i], 1'b1);
      `CHK(rd, 32'h0)
    end
    $display("test select done");
  endtask
  task automatic t_bank;
    acc(1'b1, CIR_OFF_SEL, 32'h1, 1'b1, 1'b1, 1'b0);
    acc(1'b1, CIR_OFF_SEL, 32'h2, 1'b1, 1'b0, 1'b0);
    acc(1'b0, CIR_OFF_RD, 32'h0, 1'b1, 1'b1, 1'b0);
    `CHK(rd, build_param_vec[31:0])
    acc(1'b0, CIR_OFF_RD, 32'h0, 1'b1, 1'b0, 1'b0);
    `CHK(rd, build_param_vec[63:32])
    acc(1'b0, CIR_OFF_PFR0, 32'h0, 1'b1, 1'b0, 1'b0);
    `CHK(rd, 32'h2000_0030)
    acc(1'b0, CIR_OFF_SEL, 32'h0, 1'b1, 1'b1, 1'b0);
    `CHK(rd, 32'h0)
    $display("test bank done");
  endtask
  task automatic t_access;
    foreach (m_offs[i]) begin
      acc(1'b0, m_offs[i], 32'h0, 1'b0, 1'b1, 1'b0);
      `CHK({ft, rd}, {1'b1, 32'h0})
    end
    acc(1'b1, CIR_OFF_ITCM, 32'h1, 1'b0, 1'b1, 1'b0);
    `CHK(itcm_enable_r, 1'b0)
    acc(1'b0, CIR_OFF_PFR0, 32'h0, 1'b0, 1'b1, 1'b1);
    `CHK(ft, 1'b1)
    unpriv_debug_access_enable_ns = 1'b1;
    acc(1'b0, CIR_OFF_PFR0, 32'h0, 1'b0, 1'b1, 1'b1);
    `CHK({ft, rd}, {1'b0, 32'h2000_0030})
    acc(1'b0, 12'h800, 32'h0, 1'b1, 1'b1, 1'b0);
    `CHK({ft, rd}, {1'b0, 32'h0})
    $display("test access done");
  endtask
  task automatic t_tcm;
    // enable copies show the init inputs one edge after release
    @(negedge clock);
    `CHK({itcm_enable_r, dtcm_enable_r}, 2'b10)
    acc(1'b1, CIR_OFF_ITCM, 32'hFFFF_FFFF, 1'b1, 1'b1, 1'b0);
    `CHK(rd, 32'h0)
    acc(1'b0, CIR_OFF_ITCM, 32'h0, 1'b1, 1'b1, 1'b0);
    `CHK(rd, {25'h0, instr_mem_size_input, 3'h1})
    tcm_lock_input = 1'b1;
    acc(1'b1, CIR_OFF_ITCM, 32'h0, 1'b1, 1'b1, 1'b0);
    `CHK(itcm_enable_r, 1'b1)
    tcm_lock_input = 1'b0;
    acc(1'b0, CIR_OFF_DTCM, 32'h0, 1'b1, 1'b0, 1'b0);
    `CHK(rd, 32'h0)
    acc(1'b1, CIR_OFF_DTCM, 32'h1, 1'b1, 1'b0, 1'b0);
    `CHK(dtcm_enable_r, 1'b0)
    fault_target_config = 1'b1;
    acc(1'b1, CIR_OFF_DTCM, 32'h1, 1'b1, 1'b0, 1'b0);
    acc(1'b0, CIR_OFF_DTCM, 32'h0, 1'b1, 1'b1, 1'b0);
    `CHK(rd, {25'h0, data_mem_size_input, 3'h1})
    acc(1'b1, CIR_OFF_ITCM, 32'h0, 1'b1, 1'b1, 1'b0);
    `CHK(itcm_enable_r, 1'b0)
    {sw_itcm_req, sw_dtcm_req} = 2'b11;
    @(negedge clock);
    `CHK({itcm_route_axi_r, itcm_route_tcm_r}, 2'b10)
    `CHK({dtcm_route_axi_r, dtcm_route_tcm_r}, 2'b01)
    {sw_itcm_req, sw_dtcm_req, sub_itcm_req} = 3'b001;
    @(negedge clock);
    `CHK(itcm_route_tcm_r, 1'b1)
    sub_itcm_req = 1'b0;
    $display("test memory control done");
  endtask
  // hang guard: counts as a mismatch and closes the run
  initial begin
    #200000;
    err_count++;
    stop_test();
  end
  initial begin
    for (int k = 0; k < 18; k++) build_param_vec[k*32 +: 32] = 32'hA500_0001 + k;
    for (int k = 0; k < 13; k++) sys_param_vec[k*32 +: 32] = 32'h5A00_0000 + k;
    for (int k = 0; k < 16; k++) begin
      interrupt_tier_vector[k*32 +: 32] = 32'hC000_0000 + k;
      interrupt_disable_vector[k*32 +: 32] = 32'hD000_0000 + k;
    end
    repeat (2) @(negedge clock);
    srst = 1'b0;
    t_tcm();
    t_access();
    t_bank();
    t_select();
    stop_test();
  end
endmodule
`default_nettype wire

// ---- hdl/cir_pkg.sv ----
// constants for the configuration info and memory control register bank
package cir_pkg;
  // register byte offsets within the implementation-defined block
  localparam logic [11:0] CIR_OFF_SEL   = 12'h700;
  localparam logic [11:0] CIR_OFF_RD    = 12'h704;
  localparam logic [11:0] CIR_OFF_PFR0  = 12'hD40;
  localparam logic [11:0] CIR_OFF_ITCM  = 12'hF00;
  localparam logic [11:0] CIR_OFF_DTCM  = 12'hF04;
  // selector codes
  localparam logic [31:0] CIR_SEL_FIRST = 32'h0000_0001;
  localparam logic [31:0] CIR_SEL_LAST  = 32'h0000_0012;
  localparam logic [31:0] CIR_SEL_FPU   = 32'h0000_0004;
  localparam logic [31:0] CIR_SEL_MVE   = 32'h0000_0005;
  localparam logic [31:0] CIR_SEL_MPNS  = 32'h0000_0008;
  localparam logic [31:0] CIR_SEL_MPS   = 32'h0000_0009;
  localparam logic [31:0] CIR_SEL_ATTR  = 32'h0000_000A;
  localparam logic [31:0] CIR_SEL_TIER  = 32'h0000_0020;
  localparam logic [31:0] CIR_SEL_DIS   = 32'h0000_0030;
  localparam logic [31:0] CIR_SEL_SYS0  = 32'h0000_0040;
  localparam logic [31:0] CIR_SEL_SYS1  = 32'h0000_004C;
  localparam logic [31:0] CIR_SEL_RSV0  = 32'h0000_0041;
  localparam logic [31:0] CIR_SEL_RSV1  = 32'h0000_0045;
  localparam logic [31:0] CIR_SEL_RSV2  = 32'h0000_0046;
  localparam logic [31:0] CIR_SEL_L1RD  = 32'h0000_004B;
  localparam logic [31:0] CIR_SEL_ALIAS = 32'h0000_004C;
  // parameter table geometry
  localparam int          CIR_NPARAM    = 18;
  localparam int          CIR_NSYS      = 13;
  localparam int          CIR_NSLICE    = 16;
  localparam int          CIR_VEC_W     = 512;
  // feature identification fields
  localparam logic [3:0]  CIR_RAS_V1    = 4'h2;
  localparam logic [3:0]  CIR_ISA_CMP   = 4'h3;
  localparam logic [3:0]  CIR_ISA_WIDE  = 4'h0;
  // memory control layout
  localparam int          CIR_EN_BIT    = 0;
  localparam int          CIR_SZ_LO     = 3;
  localparam int          CIR_SZ_HI     = 6;
  localparam logic [3:0]  CIR_SZ_NONE   = 4'h0;
  localparam logic [3:0]  CIR_SZ_MIN    = 4'h3;
endpackage

// ---- hdl/cir_regs.sv ----
// configuration info, feature id and memory control registers
// What this block does
// [RULE1] write-only selector picks configuration item
// [RULE2] codes 0x1..0x12 pick build parameters
// [RULE3] 0x20+n, 0x30+n return vector slices
// [RULE4] codes 0x40..0x4C pick system items
// [RULE5] tie-off items return live input values
// [RULE6] disabling tie-offs report feature unsupported
// [RULE7] readback returns selected item value
// [RULE8] alias item reads in bits 4:0
// [RULE9] unprivileged access refused with bus fault
// [RULE10] selector and readback banked per state
// [RULE11] feature id reports reliability version
// [RULE12] feature id reports instruction set support
// [RULE13] debug unprivileged reads allowed when enabled
// [RULE14] feature id shared by both states
// [RULE15] non-secure sees memory control as zero when security_ext_present is set and fault_target_config is clear
// [RULE16] lock input makes memory control read-only
// [RULE17] size field bits 6:3 encodes size
// [RULE18] size loaded at reset from inputs
// [RULE19] enable bit gates processor memory access
// [RULE20] enable resets from init input
// [RULE21] subordinate port ignores enable bit
// [RULE22] memory control shared by both states
// [RULE23] reserved codes and bits read zero
`timescale 1ns/1ps
`default_nettype none
module cir_regs (
  // clock and reset
  input  wire logic                           clock,
  input  wire logic                           srst,
  // register access port
  input  wire logic                           acc_valid,
  input  wire logic                           acc_write,
  input  wire logic [11:0]                    acc_addr,
  input  wire logic [31:0]                    acc_wdata,
  input  wire logic                           acc_priv,
  input  wire logic                           acc_secure,
  input  wire logic                           acc_debug,
  output var  logic [31:0]                    acc_rdata_r,
  output var  logic                           acc_ack_r,
  output var  logic                           bus_fault_exception_r,
  // security context
  input  wire logic                           security_ext_present,
  input  wire logic                           fault_target_config,
  input  wire logic                           unpriv_debug_access_enable_s,
  input  wire logic                           unpriv_debug_access_enable_ns,
  // build parameter values, codes 0x1 to 0x12 in order
  input  wire logic [cir_pkg::CIR_NPARAM*32-1:0] build_param_vec,
  // system item values, codes 0x40 to 0x4C in order
  input  wire logic [cir_pkg::CIR_NSYS*32-1:0]   sys_param_vec,
  input  wire logic [cir_pkg::CIR_VEC_W-1:0]     interrupt_tier_vector,
  input  wire logic [cir_pkg::CIR_VEC_W-1:0]     interrupt_disable_vector,
  // tie-off inputs
  input  wire logic                           l1_reset_disable_input,
  input  wire logic [4:0]                     memory_alias_input,
  input  wire logic                           float_unit_cfg_input,
  input  wire logic                           vector_ext_cfg_input,
  input  wire logic                           nonsecure_protection_off_input,
  input  wire logic                           secure_protection_off_input,
  input  wire logic                           attribution_unit_off_input,
  // memory control inputs
  input  wire logic                           tcm_lock_input,
  input  wire logic [3:0]                     instr_mem_size_input,
  input  wire logic [3:0]                     data_mem_size_input,
  input  wire logic                           instr_mem_enable_init_input,
  input  wire logic                           data_mem_enable_init_input,
  // memory routing
  input  wire logic                           sw_itcm_req,
  input  wire logic                           sw_dtcm_req,
  input  wire logic                           sub_itcm_req,
  input  wire logic                           sub_dtcm_req,
  output var  logic                           itcm_route_tcm_r,
  output var  logic                           dtcm_route_tcm_r,
  output var  logic                           itcm_route_axi_r,
  output var  logic                           dtcm_route_axi_r,
  output var  logic                           itcm_enable_r,
  output var  logic                           dtcm_enable_r
);
  import cir_pkg::*;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic        hit_sel;
  logic        hit_rd;
  logic        hit_pfr;
  logic        hit_itcm;
  logic        hit_dtcm;
  logic        hit_any;
  logic        dbg_pfr_ok;
  logic        refused;
  logic        ns_hidden;
  logic        wr_ok;
  logic [31:0] cur_sel;
  logic [31:0] cur_sel_s;
  logic [31:0] cur_sel_ns;
  logic [31:0] cfg_value;
  logic [31:0] pfr_value;
  logic        itcm_en_r;
  logic        dtcm_en_r;
  logic [3:0]  itcm_sz_r;
  logic [3:0]  dtcm_sz_r;

  // address decode, unmapped offsets read zero
  always_comb begin
    hit_sel  = 1'b0;
    hit_rd   = 1'b0;
    hit_pfr  = 1'b0;
    hit_itcm = 1'b0;
    hit_dtcm = 1'b0;
    if (acc_addr == CIR_OFF_SEL) begin
      hit_sel = 1'b1;
    end else if (acc_addr == CIR_OFF_RD) begin
      hit_rd = 1'b1;
    end else if (acc_addr == CIR_OFF_PFR0) begin
      hit_pfr = 1'b1;
    end else if (acc_addr == CIR_OFF_ITCM) begin
      hit_itcm = 1'b1;
    end else if (acc_addr == CIR_OFF_DTCM) begin
      hit_dtcm = 1'b1;
    end
  end

  assign hit_any = hit_sel | hit_rd | hit_pfr | hit_itcm | hit_dtcm;
  // [RULE13] debug unprivileged read
  assign dbg_pfr_ok = acc_debug && !acc_write && hit_pfr &&
                      (unpriv_debug_access_enable_s ||
                       unpriv_debug_access_enable_ns);
  // [RULE9] unprivileged access refused
  assign refused = acc_valid && hit_any && !acc_priv && !dbg_pfr_ok;
  // [RULE15] non-secure hidden view
  assign ns_hidden = security_ext_present && !fault_target_config &&
                     !acc_secure;
  assign wr_ok = acc_valid && acc_write && !refused;

  // ----------------------------------------------------------------
  // banked selector
  // ----------------------------------------------------------------
  // [RULE1] write-only selector, never on the read mux
  // [RULE10] per-state selector copies
  // one fixed view per state: a registered pick on acc_secure would lag
  // a cycle and serve the wrong bank when the state flips; costs a copy
  cir_sel_bank u_sel_s (
    .clock    (clock),
    .srst     (srst),
    .wr_en    (wr_ok && hit_sel),
    .wr_sec   (acc_secure),
    .wr_data  (acc_wdata),
    .rd_sec   (1'b1),
    .rd_sel_r (cur_sel_s)
  );

  cir_sel_bank u_sel_ns (
    .clock    (clock),
    .srst     (srst),
    .wr_en    (wr_ok && hit_sel),
    .wr_sec   (acc_secure),
    .wr_data  (acc_wdata),
    .rd_sec   (1'b0),
    .rd_sel_r (cur_sel_ns)
  );

  // the bank of the state making this access
  assign cur_sel = acc_secure ? cur_sel_s : cur_sel_ns;

  // ----------------------------------------------------------------
  // configuration readback
  // ----------------------------------------------------------------
  // selected item; readback copy per state follows its own selector
  always_comb begin
    cfg_value = '0;
    // [RULE2] build parameter table
    if (cur_sel >= CIR_SEL_FIRST && cur_sel <= CIR_SEL_LAST) begin
      cfg_value = build_param_vec[(cur_sel[4:0] - 5'd1)*32 +: 32];
      // [RULE6] tie-off disables feature
      if (cur_sel == CIR_SEL_FPU && !float_unit_cfg_input) begin
        cfg_value = '0;
      end else if (cur_sel == CIR_SEL_MVE && !vector_ext_cfg_input) begin
        cfg_value = '0;
      end else if (cur_sel == CIR_SEL_MPNS &&
                   nonsecure_protection_off_input) begin
        cfg_value = '0;
      end else if (cur_sel == CIR_SEL_MPS &&
                   secure_protection_off_input) begin
        cfg_value = '0;
      end else if (cur_sel == CIR_SEL_ATTR &&
                   attribution_unit_off_input) begin
        cfg_value = '0;
      end
    // [RULE3] interrupt vector slices
    end else if (cur_sel[31:4] == CIR_SEL_TIER[31:4]) begin
      cfg_value = interrupt_tier_vector[cur_sel[3:0]*32 +: 32];
    end else if (cur_sel[31:4] == CIR_SEL_DIS[31:4]) begin
      cfg_value = interrupt_disable_vector[cur_sel[3:0]*32 +: 32];
    // [RULE5] live tie-off value
    end else if (cur_sel == CIR_SEL_L1RD) begin
      cfg_value = {31'h0000_0000, l1_reset_disable_input};
    // [RULE8] alias value in low five bits
    end else if (cur_sel == CIR_SEL_ALIAS) begin
      cfg_value = {27'h000_0000, memory_alias_input};
    // [RULE23] reserved codes read zero
    end else if (cur_sel == CIR_SEL_RSV0 || cur_sel == CIR_SEL_RSV1 ||
                 cur_sel == CIR_SEL_RSV2) begin
      cfg_value = '0;
    // [RULE4] system items
    end else if (cur_sel >= CIR_SEL_SYS0 && cur_sel <= CIR_SEL_SYS1) begin
      cfg_value = sys_param_vec[(cur_sel[3:0])*32 +: 32];
    end
  end

  // ----------------------------------------------------------------
  // feature identification
  // ----------------------------------------------------------------
  // [RULE11] version and zero field
  // [RULE12] instruction set fields
  // [RULE14] one shared constant
  assign pfr_value = {CIR_RAS_V1, 20'h0_0000, CIR_ISA_CMP, CIR_ISA_WIDE};

  // ----------------------------------------------------------------
  // memory control registers
  // ----------------------------------------------------------------
  // [RULE18] size loaded at reset
  // [RULE17] read-only size field
  always_ff @(posedge clock) begin
    if (srst) begin
      itcm_sz_r <= instr_mem_size_input;
      dtcm_sz_r <= data_mem_size_input;
    end
  end

  // enable bits; lock and hidden view block writes
  always_ff @(posedge clock) begin
    if (srst) begin
      // [RULE20] enable from init inputs
      itcm_en_r <= instr_mem_enable_init_input;
      dtcm_en_r <= data_mem_enable_init_input;
    // [RULE16] lock holds value
    end else if (wr_ok && !tcm_lock_input && !ns_hidden) begin
      // [RULE22] one copy for both states
      if (hit_itcm) begin
        itcm_en_r <= acc_wdata[CIR_EN_BIT];
      end
      if (hit_dtcm) begin
        dtcm_en_r <= acc_wdata[CIR_EN_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // read data and fault response
  // ----------------------------------------------------------------
  // one-cycle answer; refused reads return zero and raise the fault
  always_ff @(posedge clock) begin
    if (srst) begin
      acc_rdata_r           <= '0;
      acc_ack_r             <= 1'b0;
      bus_fault_exception_r <= 1'b0;
    end else begin
      acc_ack_r             <= acc_valid;
      // [RULE9] fault pulse
      bus_fault_exception_r <= refused;
      acc_rdata_r           <= '0;
      if (acc_valid && !acc_write && !refused) begin
        // [RULE7] readback register
        if (hit_rd) begin
          acc_rdata_r <= cfg_value;
        end else if (hit_pfr) begin
          acc_rdata_r <= pfr_value;
        // [RULE23] reserved bits zero
        end else if (hit_itcm && !ns_hidden) begin
          acc_rdata_r <= {25'h000_0000, itcm_sz_r, 2'b00, itcm_en_r};
        end else if (hit_dtcm && !ns_hidden) begin
          acc_rdata_r <= {25'h000_0000, dtcm_sz_r, 2'b00, dtcm_en_r};
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // memory routing
  // ----------------------------------------------------------------
  // [RULE19] disabled goes to main manager
  // [RULE21] subordinate port always reaches memory
  always_ff @(posedge clock) begin
    if (srst) begin
      itcm_route_tcm_r <= 1'b0;
      dtcm_route_tcm_r <= 1'b0;
      itcm_route_axi_r <= 1'b0;
      dtcm_route_axi_r <= 1'b0;
      itcm_enable_r    <= 1'b0;
      dtcm_enable_r    <= 1'b0;
    end else begin
      itcm_route_tcm_r <= (sw_itcm_req && itcm_en_r) || sub_itcm_req;
      dtcm_route_tcm_r <= (sw_dtcm_req && dtcm_en_r) || sub_dtcm_req;
      itcm_route_axi_r <= sw_itcm_req && !itcm_en_r;
      dtcm_route_axi_r <= sw_dtcm_req && !dtcm_en_r;
      itcm_enable_r    <= itcm_en_r;
      dtcm_enable_r    <= dtcm_en_r;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/cir_sel_bank.sv ----
// banked selector pair: one copy per security state
`timescale 1ns/1ps
`default_nettype none
module cir_sel_bank (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // write side
  input  wire logic        wr_en,
  input  wire logic        wr_sec,
  input  wire logic [31:0] wr_data,
  // read side
  input  wire logic        rd_sec,
  output var  logic [31:0] rd_sel_r
);
  logic [31:0] sel_s_r;
  logic [31:0] sel_ns_r;

  // per-state copies, selector reset value is unknown so zero is used
  always_ff @(posedge clock) begin
    if (srst) begin
      sel_s_r  <= '0;
      sel_ns_r <= '0;
    end else if (wr_en && wr_sec) begin
      sel_s_r  <= wr_data;
    end else if (wr_en) begin
      sel_ns_r <= wr_data;
    end
  end

  // registered pick of the active copy, follows a write immediately
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_sel_r <= '0;
    end else if (wr_en && (wr_sec == rd_sec)) begin
      rd_sel_r <= wr_data;
    end else begin
      rd_sel_r <= rd_sec ? sel_s_r : sel_ns_r;
    end
  end
endmodule
`default_nettype wire
